// ---- verilog/rssq_sequencer.sv ----
// regulator start-up, fault and ready sequencer with apb register port
// assumes comparator results arrive as digital pin levels; sensed voltage is a
// same-clock digitiser code in reference steps
//
// Contract
// - active only with both enables, supply good, no fault
// - power enable drop clears faults, rearms soft-start
// - termination enable drop clears faults, rearms soft-start
// - run after supply good, stop when it drops
// - ramp to boot level, then to code target
// - one reference step per soft-start tick
// - target decoded from eight identification inputs
// - grounded select picks legacy table, else newer
// - phase three high two phases, four high three
// - overvoltage fixed before valid code, margin after
// - overvoltage releases only below trip minus hysteresis
// - ready after soft-start in regulation; drops on faults
// - ready drops below undervoltage threshold
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
module rssq_sequencer
	import rssq_pkg::*;
#(
	parameter logic [REF_W-1:0] NEW_BASE_LSB = 10'h100,
	parameter logic [REF_W-1:0] LEG_BASE_LSB = 10'h0f0
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	input wire logic power_rail_enable,
	input wire logic termination_rail_enable,
	input wire logic supply_good,
	input wire logic soft_start_tick,
	input wire logic overcurrent_trip,
	input wire logic [7:0] voltage_id_code,
	input wire logic [7:0] voltage_id_driven,
	input wire logic code_table_select,
	input wire logic code_table_driven,
	input wire logic phase_three_drive_in,
	output logic phase_three_drive_out,
	output logic phase_three_drive_oe,
	input wire logic phase_four_drive_in,
	output logic phase_four_drive_out,
	output logic phase_four_drive_oe,
	input wire logic [REF_W-1:0] sensed_output_voltage,
	output logic [REF_W-1:0] reference_level,
	output logic overvoltage_trip,
	output logic regulator_ready
);
	logic [15:0] pin_raw;
	logic [15:0] pin_s;
	logic pwr_s, vtt_s, sg_s, tick_s, oc_s, table_s, p3_s, p4_s;
	logic [7:0] vid_s;
	logic tick_d_reg, tick_p, pwr_d_reg, vtt_d_reg, go, drop;
	rssq_state_t state_reg;
	logic [REF_W-1:0] ref_reg, target_reg, ov_trip, target_next;
	logic vid_valid_reg, target_ok, fault_reg, ov_reg, ready_reg, uv, drive_live;
	logic [2:0] phases_reg;
	logic [31:0] ctrl_reg;
	logic [INT_W-1:0] int_status_reg, int_mask_reg, int_event;
	logic ready_d_reg, wr, rd, hit;
	rssq_status_t status;

	// code table decode: upper bit is valid, lower bits the target in steps
	function automatic logic [REF_W:0] decode_vid(input logic [7:0] code, input logic newer);
		logic [REF_W-1:0] base;
		logic [REF_W-1:0] c;
		base = newer ? NEW_BASE_LSB : LEG_BASE_LSB;
		c = REF_W'(code);
		if (code == 8'h00 || code == 8'hff || c >= base)
			return {1'b0, {REF_W{1'b0}}};
		return {1'b1, REF_W'(base - c)};
	endfunction

	// percentage of the target, used for both ready thresholds
	function automatic logic [REF_W-1:0] pct_of(input logic [REF_W-1:0] v, input int pct);
		return REF_W'((int'(v) * pct) / 100);
	endfunction

	// undriven identification and select pins float high via pull-ups
	assign pin_raw = {voltage_id_code | ~voltage_id_driven,
		code_table_select | ~code_table_driven, phase_four_drive_in,
		phase_three_drive_in, overcurrent_trip, soft_start_tick, supply_good,
		termination_rail_enable, power_rail_enable};

	rssq_sync3 #(.WIDTH(16), .RST_VAL(16'hff80)) u_pin_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin_in(pin_raw),
		.level_out(pin_s)
	);

	assign {vid_s, table_s, p4_s, p3_s, oc_s, tick_s, sg_s, vtt_s, pwr_s} = pin_s;
	// drop clears faults even while supply or software keep us off
	assign drop = (pwr_d_reg && !pwr_s) || (vtt_d_reg && !vtt_s);
	assign go = pwr_s && vtt_s && sg_s && ctrl_reg[CTRL_EN_BIT] && !fault_reg;
	assign tick_p = tick_s && !tick_d_reg;
	assign {target_ok, target_next} = decode_vid(vid_s, table_s);

	// edge history for the tick and enable falls
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tick_d_reg <= 1'b0;
			pwr_d_reg <= 1'b0;
			vtt_d_reg <= 1'b0;
		end
		else
		begin
			tick_d_reg <= tick_s;
			pwr_d_reg <= pwr_s;
			vtt_d_reg <= vtt_s;
		end
	end

	// decoded target follows the identification inputs every cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			target_reg <= {REF_W{1'b0}};
		else
			target_reg <= target_next;
	end

	// start-up sequence: sense phases, boot ramp, wait for code, ramp to target
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= ST_OFF;
			ref_reg <= {REF_W{1'b0}};
			vid_valid_reg <= 1'b0;
			phases_reg <= 3'd4;
		end
		else if (!go)
		begin
			state_reg <= ST_OFF;
			ref_reg <= {REF_W{1'b0}};
			vid_valid_reg <= 1'b0;
		end
		else
		begin
			case (state_reg)
				ST_OFF: state_reg <= ST_SENSE;
				ST_SENSE:
				begin
					// phase pins are only read here, before they are ever driven
					if (p3_s)
						phases_reg <= 3'd2;
					else if (p4_s)
						phases_reg <= 3'd3;
					else
						phases_reg <= 3'd4;
					state_reg <= ST_BOOT;
				end
				ST_BOOT:
				begin
					if (ref_reg >= BOOT_LSB)
						state_reg <= ST_WAIT_VID;
					else if (tick_p)
						ref_reg <= ref_reg + 1'b1;
				end
				ST_WAIT_VID:
				begin
					if (target_ok)
					begin
						vid_valid_reg <= 1'b1;
						state_reg <= ST_VID_RAMP;
					end
				end
				ST_VID_RAMP:
				begin
					// a code change mid-ramp simply redirects the ramp
					if (ref_reg == target_reg)
						state_reg <= ST_RUN;
					else if (tick_p && ref_reg < target_reg)
						ref_reg <= ref_reg + 1'b1;
					else if (tick_p)
						ref_reg <= ref_reg - 1'b1;
				end
				ST_RUN:
				begin
					if (ref_reg != target_reg)
						state_reg <= ST_VID_RAMP;
				end
				default: state_reg <= ST_OFF;
			endcase
		end
	end

	// trip level depends on whether a valid code was seen
	assign ov_trip = vid_valid_reg ? REF_W'(target_reg + OV_MARGIN_LSB) : OV_ABS_LSB;
	assign uv = sensed_output_voltage < pct_of(target_reg, UV_PCT);

	// overvoltage indication with release hysteresis
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ov_reg <= 1'b0;
		else if (sensed_output_voltage > ov_trip)
			ov_reg <= 1'b1;
		else if (sensed_output_voltage < REF_W'(ov_trip - OV_HYST_LSB))
			ov_reg <= 1'b0;
	end

	// fault latch: set wins over the clear from an enable fall
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			fault_reg <= 1'b0;
		else if (state_reg != ST_OFF && (ov_reg || oc_s))
			fault_reg <= 1'b1;
		else if (drop)
			fault_reg <= 1'b0;
	end

	// ready: set at 60 percent of target after soft-start, cleared below 50 percent
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ready_reg <= 1'b0;
		else if (state_reg != ST_RUN || oc_s || ov_reg || fault_reg || uv)
			ready_reg <= 1'b0;
		else if (sensed_output_voltage >= pct_of(target_reg, RDY_PCT))
			ready_reg <= 1'b1;
	end

	// phase pins stay released until sensed; modulation itself lives elsewhere
	assign drive_live = state_reg != ST_OFF && state_reg != ST_SENSE;
	assign phase_three_drive_out = 1'b0;
	assign phase_four_drive_out = 1'b0;
	assign phase_three_drive_oe = drive_live && phases_reg >= 3'd3;
	assign phase_four_drive_oe = drive_live && phases_reg == 3'd4;
	assign reference_level = ref_reg;
	assign overvoltage_trip = ov_reg;
	assign regulator_ready = ready_reg;

	// apb slave: zero wait states, error on unmapped offsets
	assign wr = psel && penable && pwrite;
	assign rd = psel && penable && !pwrite;
	assign pready = 1'b1;
	assign hit = paddr == CTRL_OFS || paddr == STATUS_OFS || paddr == REF_OFS ||
		paddr == TARGET_OFS || paddr == INT_STATUS_OFS || paddr == INT_MASK_OFS;
	assign pslverr = (wr || rd) && !hit;
	assign status = '{phases: phases_reg, table_newer: table_s, vid_valid: vid_valid_reg,
		fault: fault_reg, ov: ov_reg, ready: ready_reg, active: go,
		state: 3'(state_reg)};

	// control and mask registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg <= CTRL_RST;
			int_mask_reg <= INT_MASK_RST;
		end
		else if (wr && paddr == CTRL_OFS)
			ctrl_reg <= {31'h0, pwdata[CTRL_EN_BIT]};
		else if (wr && paddr == INT_MASK_OFS)
			int_mask_reg <= pwdata[INT_W-1:0];
	end

	// sticky event bits, write one to clear, a new event wins over the clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			int_status_reg <= {INT_W{1'b0}};
			ready_d_reg <= 1'b0;
		end
		else
		begin
			ready_d_reg <= ready_reg;
			if (wr && paddr == INT_STATUS_OFS)
				int_status_reg <= (int_status_reg & ~pwdata[INT_W-1:0]) | int_event;
			else
				int_status_reg <= int_status_reg | int_event;
		end
	end

	always_comb
	begin
		int_event = {INT_W{1'b0}};
		int_event[INT_OV] = ov_reg && state_reg != ST_OFF;
		int_event[INT_OC] = oc_s && state_reg != ST_OFF;
		int_event[INT_UV] = uv && state_reg == ST_RUN;
		int_event[INT_RDY_UP] = ready_reg && !ready_d_reg;
		int_event[INT_RDY_DN] = !ready_reg && ready_d_reg;
	end

	assign irq = |(int_status_reg & int_mask_reg);

	// read data mux, registered off the setup phase so it stands in the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (psel && !penable && !pwrite)
		begin
			if (paddr == CTRL_OFS)
				prdata <= ctrl_reg;
			else if (paddr == STATUS_OFS)
				prdata <= 32'(status);
			else if (paddr == REF_OFS)
				prdata <= 32'(ref_reg);
			else if (paddr == TARGET_OFS)
				prdata <= 32'(target_reg);
			else if (paddr == INT_STATUS_OFS)
				prdata <= 32'(int_status_reg);
			else if (paddr == INT_MASK_OFS)
				prdata <= 32'(int_mask_reg);
			else
				prdata <= 32'h0;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_active_needs_go: assert property (state_reg != ST_OFF |-> $past(go))
		else $error("sequencer active without all enables");
	a_pwr_drop_clear: assert property (pwr_d_reg && !pwr_s && !oc_s && !ov_reg
		|=> !fault_reg && state_reg == ST_OFF)
		else $error("power enable fall did not clear");
	a_vtt_drop_clear: assert property (vtt_d_reg && !vtt_s && !oc_s && !ov_reg
		|=> !fault_reg && state_reg == ST_OFF)
		else $error("termination enable fall did not clear");
	a_supply_stop: assert property (!sg_s |=> state_reg == ST_OFF && ref_reg == 0)
		else $error("still running without supply good");
	a_boot_ceiling: assert property (state_reg == ST_BOOT || state_reg == ST_WAIT_VID
		|-> ref_reg <= BOOT_LSB && !vid_valid_reg)
		else $error("reference above boot level before valid code");
	a_ramp_step: assert property (state_reg == ST_BOOT && ref_reg < BOOT_LSB && tick_p && go
		|=> ref_reg == $past(ref_reg) + 1'b1)
		else $error("boot ramp did not step once");
	a_no_tick_hold: assert property (go && !tick_p && state_reg != ST_OFF
		|=> $stable(ref_reg))
		else $error("reference moved without a tick");
	a_target_decode: assert property (1'b1 |=> target_reg == $past(target_next))
		else $error("target does not follow decode");
	a_phase_count: assert property (go && state_reg == ST_SENSE
		|=> phases_reg == ($past(p3_s) ? 3'd2 : $past(p4_s) ? 3'd3 : 3'd4))
		else $error("phase count decode wrong");
	a_ov_trip: assert property (sensed_output_voltage > ov_trip |=> ov_reg)
		else $error("overvoltage not flagged");
	a_ov_hold: assert property (ov_reg && sensed_output_voltage >= REF_W'(ov_trip - OV_HYST_LSB)
		|=> ov_reg)
		else $error("overvoltage released inside hysteresis");
	a_ready_gate: assert property (ready_reg |-> state_reg == ST_RUN
		|| $past(state_reg) == ST_RUN)
		else $error("ready outside regulation");
	a_ready_drop: assert property (oc_s || ov_reg || uv |=> !ready_reg)
		else $error("ready held during fault or undervoltage");

	c_reach_run: cover property (state_reg == ST_VID_RAMP ##1 state_reg == ST_RUN);
	c_ready_rise: cover property (!ready_reg ##1 ready_reg);
	c_ov_trip: cover property (!ov_reg ##1 ov_reg);
	c_two_phase: cover property (state_reg == ST_BOOT && phases_reg == 3'd2);
endmodule

// ---- verilog/rssq_pkg.sv ----
// regulator start-up sequencer: shared constants, register map and types
// assumes levels are carried as codes of one reference step (6.25 mV) each
package rssq_pkg;
	// voltage figures in microvolts, converted to reference steps below
	localparam int STEP_UV = 6250;
	localparam int BOOT_UV = 1100000;
	localparam int OV_ABS_UV = 1275000;
	localparam int OV_MARGIN_UV = 175000;
	localparam int OV_HYST_UV = 100000;
	localparam int UV_PCT = 50;
	localparam int RDY_PCT = 60;
	localparam int REF_W = 10;
	localparam logic [REF_W-1:0] BOOT_LSB = REF_W'(BOOT_UV / STEP_UV);
	localparam logic [REF_W-1:0] OV_ABS_LSB = REF_W'(OV_ABS_UV / STEP_UV);
	localparam logic [REF_W-1:0] OV_MARGIN_LSB = REF_W'(OV_MARGIN_UV / STEP_UV);
	localparam logic [REF_W-1:0] OV_HYST_LSB = REF_W'(OV_HYST_UV / STEP_UV);
	// apb register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STATUS_OFS = 8'h04;
	localparam logic [7:0] REF_OFS = 8'h08;
	localparam logic [7:0] TARGET_OFS = 8'h0c;
	localparam logic [7:0] INT_STATUS_OFS = 8'h10;
	localparam logic [7:0] INT_MASK_OFS = 8'h14;
	localparam logic [31:0] CTRL_RST = 32'h0000_0001;
	localparam int CTRL_EN_BIT = 0;
	// interrupt status / mask bit positions
	localparam int INT_W = 5;
	localparam int INT_OV = 0;
	localparam int INT_OC = 1;
	localparam int INT_UV = 2;
	localparam int INT_RDY_UP = 3;
	localparam int INT_RDY_DN = 4;
	localparam logic [INT_W-1:0] INT_MASK_RST = 5'h00;

	typedef enum {ST_OFF, ST_SENSE, ST_BOOT, ST_WAIT_VID, ST_VID_RAMP, ST_RUN} rssq_state_t;

	// status register layout, high bits first from the left
	typedef struct packed {
		logic [2:0] phases;
		logic table_newer;
		logic vid_valid;
		logic fault;
		logic ov;
		logic ready;
		logic active;
		logic [2:0] state;
	} rssq_status_t;
endpackage

// ---- verilog/rssq_sync3.sv ----
// three-stage pin synchroniser with agreement filter
// assumes each bit is an independent level from outside the pclk domain
`timescale 1ns/1ps
module rssq_sync3 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
)(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] level_out
);
	logic [WIDTH-1:0] s1_reg;
	logic [WIDTH-1:0] s2_reg;
	logic [WIDTH-1:0] s3_reg;
	logic [WIDTH-1:0] level_reg;

	// first stage feeds only the second; a bit changes once stages two and three agree
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s1_reg <= RST_VAL;
			s2_reg <= RST_VAL;
			s3_reg <= RST_VAL;
			level_reg <= RST_VAL;
		end
		else
		begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			for (int i = 0; i < WIDTH; i++)
			begin
				if (s2_reg[i] == s3_reg[i])
					level_reg[i] <= s3_reg[i];
			end
		end
	end

	assign level_out = level_reg;
endmodule

// ---- test/rssq_far_model.sv ----
// far side: processor code pins, table strap, phase straps, output stage, ss oscillator
// assumes the bench sets strap and code values; output tracks the reference unless held
`timescale 1ns/1ps
module rssq_far_model (
	input wire logic pclk,
	input wire logic [rssq_pkg::REF_W-1:0] reference_level,
	input wire logic [7:0] vid_val,
	input wire logic [7:0] vid_drv,
	input wire logic sel_val,
	input wire logic sel_drv,
	input wire logic tie3,
	input wire logic tie4,
	input wire logic hold,
	input wire logic [rssq_pkg::REF_W-1:0] hold_val,
	input wire logic p3_out,
	input wire logic p3_oe,
	input wire logic p4_out,
	input wire logic p4_oe,
	output logic [7:0] voltage_id_code,
	output logic code_table_select,
	output logic phase_three_drive_in,
	output logic phase_four_drive_in,
	output logic [rssq_pkg::REF_W-1:0] sensed_output_voltage,
	output logic soft_start_tick
);
	import rssq_pkg::*;
	logic [3:0] div_reg = 4'h0;
	// undriven code bits float up through the pull-up
	assign voltage_id_code = vid_val | ~vid_drv;
	// a floating strap reads high; only a driven low grounds it
	assign code_table_select = sel_drv ? sel_val : 1'b1;
	// wire level: the controller wins while enabled, otherwise the strap tie
	assign phase_three_drive_in = p3_oe ? p3_out : tie3;
	assign phase_four_drive_in = p4_oe ? p4_out : tie4;
	// ideal output stage; the bench may force a level to reach the monitors
	assign sensed_output_voltage = hold ? hold_val : reference_level;
	// slow tick so each level survives the pin filter
	always_ff @(posedge pclk)
	begin
		div_reg <= div_reg + 4'h1;
	end
	assign soft_start_tick = div_reg[3];
endmodule

// ---- test/regulator_startup_fault_sequencer_tb_top.sv ----
// self-checking bench for the regulator start-up sequencer
// assumes the far-side model supplies code pins, straps, output stage and oscillator
`timescale 1ns/1ps
module regulator_startup_fault_sequencer_tb_top;
	import rssq_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic pwr = 1'b0, vtt = 1'b0, sup = 1'b0, oc = 1'b0;
	logic [7:0] vid_val = 8'hff, vid_drv = 8'hff;
	logic sel_val = 1'b1, sel_drv = 1'b1, tie3 = 1'b0, tie4 = 1'b0, hold = 1'b0;
	logic [REF_W-1:0] hold_val = '0, ref_prev = '0, sensed, refl;
	logic [31:0] prdata, rv;
	logic pready, pslverr, irq, ssel, p3i, p3o, p3e, p4i, p4o, p4e, ovt, rdy, tick;
	logic [7:0] vcode;
	int errors = 0, checks = 0;

	rssq_sequencer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .power_rail_enable(pwr), .termination_rail_enable(vtt),
		.supply_good(sup), .soft_start_tick(tick), .overcurrent_trip(oc),
		.voltage_id_code(vcode), .voltage_id_driven(vid_drv), .code_table_select(ssel),
		.code_table_driven(sel_drv), .phase_three_drive_in(p3i), .phase_three_drive_out(p3o),
		.phase_three_drive_oe(p3e), .phase_four_drive_in(p4i), .phase_four_drive_out(p4o),
		.phase_four_drive_oe(p4e), .sensed_output_voltage(sensed), .reference_level(refl),
		.overvoltage_trip(ovt), .regulator_ready(rdy));
	rssq_far_model far_u (.pclk(pclk), .reference_level(refl), .vid_val(vid_val),
		.vid_drv(vid_drv), .sel_val(sel_val), .sel_drv(sel_drv), .tie3(tie3), .tie4(tie4),
		.hold(hold), .hold_val(hold_val), .p3_out(p3o), .p3_oe(p3e), .p4_out(p4o),
		.p4_oe(p4e), .voltage_id_code(vcode), .code_table_select(ssel),
		.phase_three_drive_in(p3i), .phase_four_drive_in(p4i),
		.sensed_output_voltage(sensed), .soft_start_tick(tick));

	initial
	begin
		forever #12.5 pclk = ~pclk;
	end

	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// one apb transfer; request held until pready is seen high at a rising edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 50);
		chk("pready", 32'(pready), 32'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h0, r, e);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask

	// polling keeps the wait bounded even if the sequence stalls
	task automatic wait_st(input logic [2:0] s);
		int i;
		logic [31:0] r;
		i = 0;
		do
		begin
			rd(STATUS_OFS, r);
			i++;
		end
		while (r[2:0] !== s && i < 4000);
		chk("state", 32'(r[2:0]), 32'(s));
	endtask

	task automatic wait_rdy(input logic e);
		int i;
		for (i = 0; i < 50 && rdy !== e; i++)
			@(posedge pclk);
		chk("ready", 32'(rdy), 32'(e));
	endtask

	task automatic tend(input string n);
		$display("test %s finished", n);
	endtask

	// reference moves one step at a time except when dropped by shutdown
	always @(posedge pclk)
	begin
		if (presetn && refl !== ref_prev && refl !== '0)
			chk("ref step", 32'(refl - ref_prev == 10'h001 || ref_prev - refl == 10'h001), 32'h1);
		ref_prev <= refl;
	end

	task automatic t_reset();
		logic [31:0] r;
		logic e;
		chk("ref rst", 32'(refl), 32'h0);
		chk("rdy rst", 32'(rdy), 32'h0);
		chk("irq rst", 32'(irq), 32'h0);
		rd(CTRL_OFS, r);
		chk("ctrl rst", r, CTRL_RST);
		rd(INT_MASK_OFS, r);
		chk("mask rst", r, 32'h0);
		apb(1'b0, 8'h3c, 32'h0, r, e);
		chk("unmapped err", 32'(e), 32'h1);
		pwr <= 1'b1;
		sup <= 1'b1;
		cyc(20);
		rd(STATUS_OFS, r);
		chk("gated state", 32'(r[3:0]), 32'h0);
		chk("gated ref", 32'(refl), 32'h0);
		vtt <= 1'b1;
		wait_st(3'd3);
		chk("boot ref", 32'(refl), 32'd176);
		tend("reset_boot");
	endtask

	task automatic t_ov_abs();
		wr(INT_MASK_OFS, 32'h1 << INT_OV);
		hold_val <= 10'd204;
		hold <= 1'b1;
		cyc(4);
		chk("ov 204", 32'(ovt), 32'h0);
		hold_val <= 10'd205;
		cyc(4);
		chk("ov 205", 32'(ovt), 32'h1);
		chk("irq ov", 32'(irq), 32'h1);
		rd(STATUS_OFS, rv);
		chk("fault", 32'(rv[6]), 32'h1);
		hold_val <= 10'd188;
		cyc(4);
		chk("ov 188", 32'(ovt), 32'h1);
		hold_val <= 10'd187;
		cyc(4);
		chk("ov 187", 32'(ovt), 32'h0);
		wr(INT_STATUS_OFS, 32'h1 << INT_OV);
		cyc(1);
		chk("irq clr", 32'(irq), 32'h0);
		vtt <= 1'b0;
		hold <= 1'b0;
		cyc(8);
		rd(STATUS_OFS, rv);
		chk("vtt clr", 32'(rv[6]), 32'h0);
		tend("ov_abs");
	endtask

	task automatic t_table();
		vid_val <= 8'h40;
		sel_val <= 1'b0;
		cyc(8);
		rd(TARGET_OFS, rv);
		chk("legacy", rv, 32'h0b0);
		sel_drv <= 1'b0;
		cyc(8);
		rd(TARGET_OFS, rv);
		chk("newer", rv, 32'h0c0);
		vid_drv <= 8'h0f;
		vid_val <= 8'h05;
		cyc(8);
		rd(TARGET_OFS, rv);
		chk("pullup", rv, 32'h00b);
		vid_drv <= 8'hff;
		vid_val <= 8'h40;
		tend("table");
	endtask

	task automatic t_run();
		vtt <= 1'b1;
		wait_st(3'd5);
		chk("run ref", 32'(refl), 32'd192);
		wait_rdy(1'b1);
		rd(STATUS_OFS, rv);
		chk("phases", 32'(rv[11:9]), 32'd4);
		chk("oe four", 32'({p3e, p4e}), 32'h3);
		hold_val <= 10'd96;
		hold <= 1'b1;
		cyc(4);
		chk("uv 96", 32'(rdy), 32'h1);
		hold_val <= 10'd95;
		cyc(4);
		chk("uv 95", 32'(rdy), 32'h0);
		hold <= 1'b0;
		wait_rdy(1'b1);
		sup <= 1'b0;
		cyc(8);
		chk("sup ref", 32'(refl), 32'h0);
		sup <= 1'b1;
		wait_st(3'd5);
		tend("run");
	endtask

	// overcurrent in regulation: ready drops, fault latches until an enable falls
	task automatic t_oc();
		wait_rdy(1'b1);
		wr(INT_MASK_OFS, 32'h1 << INT_OC);
		oc <= 1'b1;
		cyc(8);
		chk("rdy oc", 32'(rdy), 32'h0);
		chk("irq oc", 32'(irq), 32'h1);
		rd(INT_STATUS_OFS, rv);
		chk("oc flag", 32'(rv[INT_OC]), 32'h1);
		oc <= 1'b0;
		cyc(8);
		rd(STATUS_OFS, rv);
		chk("oc latch", 32'(rv[6:0]), 32'h40);
		pwr <= 1'b0;
		cyc(8);
		pwr <= 1'b1;
		wait_st(3'd5);
		tend("overcurrent");
	endtask

	task automatic t_ovm();
		hold_val <= 10'd220;
		hold <= 1'b1;
		cyc(4);
		chk("ov 220", 32'(ovt), 32'h0);
		hold_val <= 10'd221;
		cyc(4);
		chk("ov 221", 32'(ovt), 32'h1);
		chk("rdy ov", 32'(rdy), 32'h0);
		pwr <= 1'b0;
		hold <= 1'b0;
		cyc(8);
		rd(STATUS_OFS, rv);
		chk("pwr clr", 32'(rv[6]), 32'h0);
		tend("ov_margin");
	endtask

	task automatic t_phase();
		tie3 <= 1'b1;
		pwr <= 1'b1;
		wait_st(3'd2);
		rd(STATUS_OFS, rv);
		chk("two ph", 32'(rv[11:9]), 32'd2);
		chk("two oe", 32'({p3e, p4e}), 32'h0);
		pwr <= 1'b0;
		tie3 <= 1'b0;
		tie4 <= 1'b1;
		cyc(8);
		pwr <= 1'b1;
		wait_st(3'd2);
		rd(STATUS_OFS, rv);
		chk("three ph", 32'(rv[11:9]), 32'd3);
		chk("three oe", 32'({p3e, p4e}), 32'h2);
		wr(CTRL_OFS, 32'h0);
		rd(STATUS_OFS, rv);
		chk("ctrl off", 32'(rv[3:0]), 32'h0);
		tend("phase");
	endtask

	task automatic test_done();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial
	begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_ov_abs();
		t_table();
		t_run();
		t_oc();
		t_ovm();
		t_phase();
		test_done();
	end

	// the run needs about twelve thousand cycles
	initial
	begin
		repeat (60000) @(posedge pclk);
		errors++;
		test_done();
	end
endmodule
